// *** verilog/pcld_defines.svh ***
`ifndef PCLD_DEFINES_SVH
`define PCLD_DEFINES_SVH

// Register indices; byte address is four times the index
`define PCLD_IDX_PC_LOW 12'h002
`define PCLD_IDX_PC_LATCH 12'h00a
`define PCLD_IDX_STATUS_SHD 12'hfe4
`define PCLD_IDX_WREG_SHD 12'hfe5
`define PCLD_IDX_BSR_SHD 12'hfe6
`define PCLD_IDX_LATCH_SHD 12'hfe7
`define PCLD_IDX_FSR0L_SHD 12'hfe8
`define PCLD_IDX_FSR0H_SHD 12'hfe9
`define PCLD_IDX_FSR1L_SHD 12'hfea
`define PCLD_IDX_FSR1H_SHD 12'hfeb
`define PCLD_IDX_STK_PTR 12'hfed
`define PCLD_IDX_STK_LOW 12'hfee
`define PCLD_IDX_STK_HIGH 12'hfef
// Top data bank, debug only: indices f80..fff
`define PCLD_DBG_BANK 5'h1f

// Field masks of the narrow registers
`define PCLD_MASK_STATUS 8'h07
`define PCLD_MASK_BSR 8'h1f
`define PCLD_MASK_LATCH 8'h7f
`define PCLD_MASK_SPTR 8'h1f

// Reset values
`define PCLD_RST_PC 15'h0000
`define PCLD_RST_SPTR 5'h1f
`define PCLD_RST_BYTE 8'h00

`endif

// *** verilog/pcld_pkg.sv ***
package pcld_pkg;

  // Program counter operation of the current instruction
  typedef enum logic [2:0] {
    PCLD_OP_HOLD = 3'b000,
    PCLD_OP_STEP = 3'b001,
    PCLD_OP_WRLOW = 3'b010,
    PCLD_OP_CALL = 3'b011,
    PCLD_OP_CALLACC = 3'b100,
    PCLD_OP_JMPACC = 3'b101,
    PCLD_OP_JMPLIT = 3'b110,
    PCLD_OP_RET = 3'b111
  } pcld_op_t;

  // Request from instruction execution
  typedef struct packed {
    pcld_op_t op;
    logic [10:0] operand;
    logic [7:0] wreg;
    logic [7:0] result;
  } pcld_exec_t;

  // Normal context captured into the shadows
  typedef struct packed {
    logic [2:0] status;
    logic [7:0] wreg;
    logic [4:0] bsr;
    logic [15:0] fsr0;
    logic [15:0] fsr1;
  } pcld_ctx_t;

endpackage

// *** verilog/pcld_core.sv ***
// Local design decision: the APB register port.
`include "pcld_defines.svh"

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - The program counter is 15 bits and its low byte is a software read/write register.
// - The upper counter bits have no register of their own; bus writes of the low byte load them only from the high latch.
// - Any reset clears the whole program counter to zero.
// - An instruction write of the low byte, or a bus write while the operation is hold, loads the upper seven bits from the high latch in the same step.
// - A direct call loads low byte and upper bits 2..0 from the operand and bits 6..3 from the latch.
// - A call through the accumulator loads the low byte from it and all upper bits from the latch.
// - A branch by the accumulator loads PC plus 1 plus the unsigned accumulator.
// - A literal branch loads PC plus 1 plus the sign-extended nine-bit literal.
// - Both branch forms add across the full counter width, crossing 256-location blocks.
// - Shadow copies hold flags, accumulator, bank select, high latch and both pointer pairs.
// - The top data bank is reachable only in debug mode; other accesses to it read zero and write nothing.
// - Unimplemented locations and bits read as zero.
// - The low byte of the selected stack entry is a register whose contents are unknown at reset.
// - A call increments the stack pointer then stores; a return restores then decrements.
module pcld_core #(
  parameter int STK_DEPTH = 16
) (
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic clkEn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [13:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Instruction execution side
  input wire pcld_pkg::pcld_exec_t execReq,
  input wire logic debugMode,
  input wire logic ctxSave,
  input wire pcld_pkg::pcld_ctx_t ctxIn,
  // Counter view
  output logic [14:0] pcOut,
  output logic [4:0] stkPtrOut
);
  import pcld_pkg::*;

  localparam int SP_W = $clog2(STK_DEPTH) + 1;
  localparam int IX_W = $clog2(STK_DEPTH);

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  // Full-width counter addition
  function automatic logic [14:0] pcAdd(input logic [14:0] base, input logic [14:0] off);
    logic [15:0] sum;
    sum = {1'b0, base} + {1'b0, off};
    return sum[14:0];
  endfunction

  // Zero-extend a byte masked to its implemented bits
  function automatic logic [31:0] rdByte(input logic [7:0] val, input logic [7:0] mask);
    return {24'h000000, val & mask};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  logic [14:0] pc_ff;
  logic [6:0] pcLatch_ff;
  logic [SP_W-1:0] stack_pointer_ff;
  logic [14:0] stack_ff [STK_DEPTH];
  logic [2:0] statusShd_ff;
  logic [7:0] wregShd_ff;
  logic [4:0] bsrShd_ff;
  logic [6:0] latchShd_ff;
  logic [15:0] fsr0Shd_ff;
  logic [15:0] fsr1Shd_ff;
  logic pready_ff;
  logic [31:0] prdata_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  wire [11:0] regIdx = paddr[13:2];
  wire inDbgBank = regIdx[11:7] == `PCLD_DBG_BANK;
  wire bankOpen = !inDbgBank || debugMode;
  wire apbAccess = psel && penable && !pready_ff;
  wire apbCommit = psel && penable && pready_ff;
  wire apbWr = clkEn && apbCommit && pwrite && bankOpen;
  wire wrPcLow = apbWr && regIdx == `PCLD_IDX_PC_LOW;
  wire wrLatch = apbWr && regIdx == `PCLD_IDX_PC_LATCH;
  wire wrStatusShd = apbWr && regIdx == `PCLD_IDX_STATUS_SHD;
  wire wrWregShd = apbWr && regIdx == `PCLD_IDX_WREG_SHD;
  wire wrBsrShd = apbWr && regIdx == `PCLD_IDX_BSR_SHD;
  wire wrLatchShd = apbWr && regIdx == `PCLD_IDX_LATCH_SHD;
  wire wrFsr0L = apbWr && regIdx == `PCLD_IDX_FSR0L_SHD;
  wire wrFsr0H = apbWr && regIdx == `PCLD_IDX_FSR0H_SHD;
  wire wrFsr1L = apbWr && regIdx == `PCLD_IDX_FSR1L_SHD;
  wire wrFsr1H = apbWr && regIdx == `PCLD_IDX_FSR1H_SHD;
  wire wrSp = apbWr && regIdx == `PCLD_IDX_STK_PTR;
  wire wrTosL = apbWr && regIdx == `PCLD_IDX_STK_LOW;
  wire wrTosH = apbWr && regIdx == `PCLD_IDX_STK_HIGH;

  ////////////////////////////////////////////////////////////////////////////
  // Counter next value

  wire [IX_W-1:0] tosIdx = stack_pointer_ff[IX_W-1:0];
  wire [14:0] tosVal = stack_ff[tosIdx];
  wire [14:0] pcInc = pcAdd(pc_ff, 15'h0001);
  wire [14:0] litOff = {{6{execReq.operand[8]}}, execReq.operand[8:0]};
  wire [14:0] accOff = {7'h00, execReq.wreg};
  wire [14:0] callTgt = {pcLatch_ff[6:3], execReq.operand[10:0]};
  wire [14:0] callAccTgt = {pcLatch_ff, execReq.wreg};
  wire [14:0] wrLowTgt = {pcLatch_ff, execReq.result};
  wire [14:0] apbLowTgt = {pcLatch_ff, pwdata[7:0]};
  wire isCall = execReq.op == PCLD_OP_CALL || execReq.op == PCLD_OP_CALLACC;
  wire isRet = execReq.op == PCLD_OP_RET;
  wire [SP_W-1:0] spInc = SP_W'(stack_pointer_ff + 1'b1);
  wire [SP_W-1:0] spDec = SP_W'(stack_pointer_ff - 1'b1);
  logic [14:0] nxt_pc;

  // Select the counter load for the current instruction
  always_comb
  begin
    case (execReq.op)
      PCLD_OP_STEP: nxt_pc = pcInc;
      PCLD_OP_WRLOW: nxt_pc = wrLowTgt;
      PCLD_OP_CALL: nxt_pc = callTgt;
      PCLD_OP_CALLACC: nxt_pc = callAccTgt;
      PCLD_OP_JMPACC: nxt_pc = pcAdd(pcInc, accOff);
      PCLD_OP_JMPLIT: nxt_pc = pcAdd(pcInc, litOff);
      PCLD_OP_RET: nxt_pc = tosVal;
      default: nxt_pc = wrPcLow ? apbLowTgt : pc_ff;
    endcase
  end

  // Program counter; upper bits have no bus path of their own
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      pc_ff <= `PCLD_RST_PC;
    else if (clkEn)
      pc_ff <= nxt_pc;
  end

  // High latch, written by software only
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      pcLatch_ff <= 7'h00;
    else if (wrLatch)
      pcLatch_ff <= pwdata[6:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stack

  // Pointer: push increments first, pop decrements after the read
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      stack_pointer_ff <= `PCLD_RST_SPTR;
    else if (clkEn && isCall)
      stack_pointer_ff <= spInc;
    else if (clkEn && isRet)
      stack_pointer_ff <= spDec;
    else if (wrSp)
      stack_pointer_ff <= pwdata[SP_W-1:0];
  end

  // Entries carry no reset, their contents start unknown
  always_ff @(posedge core_clk)
  begin
    if (clkEn && isCall)
      stack_ff[spInc[IX_W-1:0]] <= pcInc;
    else if (wrTosL)
      stack_ff[tosIdx] <= {tosVal[14:8], pwdata[7:0]};
    else if (wrTosH)
      stack_ff[tosIdx] <= {pwdata[6:0], tosVal[7:0]};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shadow context

  // Capture on context save, else software write
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      statusShd_ff <= 3'h0;
      wregShd_ff <= `PCLD_RST_BYTE;
      bsrShd_ff <= 5'h00;
      latchShd_ff <= 7'h00;
      fsr0Shd_ff <= 16'h0000;
      fsr1Shd_ff <= 16'h0000;
    end
    else if (clkEn && ctxSave)
    begin
      statusShd_ff <= ctxIn.status;
      wregShd_ff <= ctxIn.wreg;
      bsrShd_ff <= ctxIn.bsr;
      latchShd_ff <= pcLatch_ff;
      fsr0Shd_ff <= ctxIn.fsr0;
      fsr1Shd_ff <= ctxIn.fsr1;
    end
    else
    begin
      if (wrStatusShd)
        statusShd_ff <= pwdata[2:0];
      if (wrWregShd)
        wregShd_ff <= pwdata[7:0];
      if (wrBsrShd)
        bsrShd_ff <= pwdata[4:0];
      if (wrLatchShd)
        latchShd_ff <= pwdata[6:0];
      if (wrFsr0L)
        fsr0Shd_ff[7:0] <= pwdata[7:0];
      if (wrFsr0H)
        fsr0Shd_ff[15:8] <= pwdata[7:0];
      if (wrFsr1L)
        fsr1Shd_ff[7:0] <= pwdata[7:0];
      if (wrFsr1H)
        fsr1Shd_ff[15:8] <= pwdata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  logic [31:0] rdValue;

  // Unimplemented locations and bits read zero
  always_comb
  begin
    case (regIdx)
      `PCLD_IDX_PC_LOW: rdValue = rdByte(pc_ff[7:0], 8'hff);
      `PCLD_IDX_PC_LATCH: rdValue = rdByte({1'b0, pcLatch_ff}, `PCLD_MASK_LATCH);
      `PCLD_IDX_STATUS_SHD: rdValue = rdByte({5'h00, statusShd_ff}, `PCLD_MASK_STATUS);
      `PCLD_IDX_WREG_SHD: rdValue = rdByte(wregShd_ff, 8'hff);
      `PCLD_IDX_BSR_SHD: rdValue = rdByte({3'h0, bsrShd_ff}, `PCLD_MASK_BSR);
      `PCLD_IDX_LATCH_SHD: rdValue = rdByte({1'b0, latchShd_ff}, `PCLD_MASK_LATCH);
      `PCLD_IDX_FSR0L_SHD: rdValue = rdByte(fsr0Shd_ff[7:0], 8'hff);
      `PCLD_IDX_FSR0H_SHD: rdValue = rdByte(fsr0Shd_ff[15:8], 8'hff);
      `PCLD_IDX_FSR1L_SHD: rdValue = rdByte(fsr1Shd_ff[7:0], 8'hff);
      `PCLD_IDX_FSR1H_SHD: rdValue = rdByte(fsr1Shd_ff[15:8], 8'hff);
      `PCLD_IDX_STK_PTR: rdValue = rdByte(8'(stack_pointer_ff), `PCLD_MASK_SPTR);
      `PCLD_IDX_STK_LOW: rdValue = rdByte(tosVal[7:0], 8'hff);
      `PCLD_IDX_STK_HIGH: rdValue = rdByte({1'b0, tosVal[14:8]}, `PCLD_MASK_LATCH);
      default: rdValue = 32'h00000000;
    endcase
  end

  // APB answer: ready one cycle into the access phase
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pready_ff <= 1'b0;
      prdata_ff <= 32'h00000000;
    end
    else if (clkEn)
    begin
      pready_ff <= apbAccess;
      if (apbAccess)
        prdata_ff <= (bankOpen && !pwrite) ? rdValue : 32'h00000000;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = 1'b0 & pready_ff;
  assign pcOut = pc_ff;
  assign stkPtrOut = 5'(stack_pointer_ff);

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  a_call_target:
    assert property (clkEn && execReq.op == PCLD_OP_CALL
      |=> pc_ff == {$past(pcLatch_ff[6:3]), $past(execReq.operand)})
    else $error("direct call target wrong");
  a_acc_call_target:
    assert property (clkEn && execReq.op == PCLD_OP_CALLACC
      |=> pc_ff == {$past(pcLatch_ff), $past(execReq.wreg)})
    else $error("accumulator call target wrong");
  a_acc_jump_target:
    assert property (clkEn && execReq.op == PCLD_OP_JMPACC
      |=> pc_ff == 15'($past(pc_ff) + 15'h0001 + {7'h00, $past(execReq.wreg)}))
    else $error("accumulator branch target wrong");
  a_lit_jump_back:
    assert property (clkEn && execReq.op == PCLD_OP_JMPLIT && execReq.operand[8]
      |=> pc_ff == 15'($past(pc_ff) + 15'h0001 - (15'h0200 - {6'h00, $past(execReq.operand[8:0])})))
    else $error("negative literal branch target wrong");
  a_lit_jump_fwd:
    assert property (clkEn && execReq.op == PCLD_OP_JMPLIT && !execReq.operand[8]
      |=> pc_ff == 15'($past(pc_ff) + 15'h0001 + {6'h00, $past(execReq.operand[8:0])}))
    else $error("positive literal branch target wrong");
  a_low_write_loads:
    assert property (clkEn && execReq.op == PCLD_OP_WRLOW
      |=> pc_ff[14:8] == $past(pcLatch_ff) && pc_ff[7:0] == $past(execReq.result))
    else $error("low byte write did not load latch");
  a_step_advance:
    assert property (clkEn && execReq.op == PCLD_OP_STEP |=> pc_ff == 15'($past(pc_ff) + 15'h0001))
    else $error("counter did not advance");
  a_push_order:
    assert property (clkEn && isCall
      |=> stack_pointer_ff == SP_W'($past(stack_pointer_ff) + 1'b1) && tosVal == 15'($past(pc_ff) + 15'h0001))
    else $error("push order wrong");
  a_pop_order:
    assert property (clkEn && isRet
      |=> pc_ff == $past(tosVal) && stack_pointer_ff == SP_W'($past(stack_pointer_ff) - 1'b1))
    else $error("pop order wrong");
  a_debug_bank_gate:
    assert property (clkEn && apbAccess && inDbgBank && !debugMode
      |=> pready_ff && prdata_ff == 32'h00000000)
    else $error("debug bank leaked");
  a_unmapped_zero:
    assert property (clkEn && apbAccess && !pwrite && (regIdx == 12'hfec || regIdx == 12'h003)
      |=> prdata_ff == 32'h00000000)
    else $error("unmapped read not zero");
  a_ready_one_cycle:
    assert property (pready_ff && clkEn |=> !pready_ff)
    else $error("ready stood too long");
  a_bus_low_load:
    assert property (wrPcLow && execReq.op == PCLD_OP_HOLD
      |=> pc_ff == {$past(pcLatch_ff), $past(pwdata[7:0])})
    else $error("bus low byte write did not load latch");
  a_shadow_capture:
    assert property (clkEn && ctxSave
      |=> wregShd_ff == $past(ctxIn.wreg) && latchShd_ff == $past(pcLatch_ff)
        && fsr1Shd_ff == $past(ctxIn.fsr1))
    else $error("context not captured");
  a_freeze_hold:
    assert property (!clkEn |=> pc_ff == $past(pc_ff) && stack_pointer_ff == $past(stack_pointer_ff))
    else $error("state moved while frozen");

  // Main scenarios reached by the bench
  c_call_return: cover property (clkEn && isCall ##[1:20] clkEn && isRet);
  c_lit_back: cover property (clkEn && execReq.op == PCLD_OP_JMPLIT && execReq.operand[8]);
  c_shadow_read: cover property (apbAccess && debugMode && regIdx == `PCLD_IDX_WREG_SHD);
  c_low_write: cover property (wrPcLow);
  c_frozen_step: cover property (!clkEn && execReq.op == PCLD_OP_STEP);

endmodule

// *** test/program_counter_load_tb.sv ***
`include "pcld_defines.svh"

module program_counter_load_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pcld_pkg::*;

  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [13:0] paddr = 14'h0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  pcld_exec_t execReq = '{op: PCLD_OP_HOLD, operand: 11'h000, wreg: 8'h00, result: 8'h00};
  logic debugMode = 1'b0;
  logic clkEn = 1'b1;
  logic ctxSave = 1'b0;
  pcld_ctx_t ctxIn = '{status: 3'h5, wreg: 8'ha5, bsr: 5'h13, fsr0: 16'h1234, fsr1: 16'hbeef};
  logic [14:0] pcOut;
  logic [4:0] stkPtrOut;
  int failures = 0;
  int checked = 0;
  logic [7:0] rd;
  logic [11:0] shIdx [8];
  logic [7:0] shExp [8];

  ////////////////////////////////////////////////////////////////////////////
  // Clock and design
  always #12.5 core_clk = ~core_clk;

  pcld_core i_dut (
    .core_clk(core_clk), .arst_n(arst_n), .clkEn(clkEn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .execReq(execReq), .debugMode(debugMode), .ctxSave(ctxSave), .ctxIn(ctxIn),
    .pcOut(pcOut), .stkPtrOut(stkPtrOut)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Comparison and closing
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // APB transfer on one register index; byte address is four times the index
  task automatic apb(input logic wr, input logic [11:0] idx, input logic [7:0] d, output logic [7:0] r);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h00_0000, d};
    @(posedge core_clk);
    penable <= 1'b1;
    // Request stands until pready is sampled high at a rising edge
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
      chk(32'hdead_0000, 32'h0000_0000);
    r = prdata[7:0];
    if (!wr)
      chk({8'h00, prdata[31:8]}, 32'h0000_0000);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // One instruction, then back to hold; counter looked at mid-cycle
  task automatic exec(input pcld_op_t o, input logic [10:0] k, input logic [7:0] w);
    @(posedge core_clk);
    execReq <= '{op: o, operand: k, wreg: w, result: w}; // Result doubles as the written low byte
    @(posedge core_clk);
    execReq <= '{op: PCLD_OP_HOLD, operand: 11'h000, wreg: 8'h00, result: 8'h00};
    @(negedge core_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog
  initial
  begin
    #(25ns * 4000);
    failures++;
    close_out();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Tests
  initial
  begin
    repeat (8) @(posedge core_clk);
    arst_n <= 1'b1;
    @(negedge core_clk);
    chk(pcOut, 15'h0000);
    chk(stkPtrOut, 5'h1f);
    // Latch keeps seven bits; low byte write loads all 15 bits
    apb(1'b1, `PCLD_IDX_PC_LATCH, 8'hd5, rd);
    apb(1'b0, `PCLD_IDX_PC_LATCH, 8'h00, rd);
    chk(rd, 8'h55);
    apb(1'b1, `PCLD_IDX_PC_LOW, 8'h34, rd);
    @(negedge core_clk);
    chk(pcOut, 15'h5534);
    apb(1'b0, `PCLD_IDX_PC_LOW, 8'h00, rd);
    chk(rd, 8'h34);
    exec(PCLD_OP_STEP, 11'h000, 8'h00);
    chk(pcOut, 15'h5535);
    // Enable low: a step request leaves the counter alone
    @(posedge core_clk);
    clkEn <= 1'b0;
    execReq <= '{op: PCLD_OP_STEP, operand: 11'h000, wreg: 8'h00, result: 8'h00};
    @(posedge core_clk);
    clkEn <= 1'b1;
    execReq <= '{op: PCLD_OP_HOLD, operand: 11'h000, wreg: 8'h00, result: 8'h00};
    @(negedge core_clk);
    chk(pcOut, 15'h5535);
    // Direct call, stack view, return
    exec(PCLD_OP_CALL, 11'h7ff, 8'h00);
    chk(pcOut, 15'h57ff);
    chk(stkPtrOut, 5'h00);
    @(posedge core_clk);
    debugMode <= 1'b1;
    apb(1'b0, `PCLD_IDX_STK_LOW, 8'h00, rd);
    chk(rd, 8'h36);
    apb(1'b0, `PCLD_IDX_STK_HIGH, 8'h00, rd);
    chk(rd, 8'h55);
    apb(1'b0, `PCLD_IDX_STK_PTR, 8'h00, rd);
    chk(rd, 8'h00);
    exec(PCLD_OP_RET, 11'h000, 8'h00);
    chk(pcOut, 15'h5536);
    chk(stkPtrOut, 5'h1f);
    // Computed call and both branch forms across 256-location blocks
    exec(PCLD_OP_CALLACC, 11'h000, 8'h9a);
    chk(pcOut, 15'h559a);
    exec(PCLD_OP_JMPACC, 11'h000, 8'hff);
    chk(pcOut, 15'h569a);
    exec(PCLD_OP_JMPLIT, 11'h100, 8'h00);
    chk(pcOut, 15'h559b);
    exec(PCLD_OP_JMPLIT, 11'h6ff, 8'h00);
    chk(pcOut, 15'h569b);
    // Counter wraps within 15 bits
    apb(1'b1, `PCLD_IDX_PC_LATCH, 8'h7f, rd);
    apb(1'b1, `PCLD_IDX_PC_LOW, 8'hff, rd);
    exec(PCLD_OP_STEP, 11'h000, 8'h00);
    chk(pcOut, 15'h0000);
    // Shadow capture read back in debug mode
    @(posedge core_clk);
    ctxSave <= 1'b1;
    @(posedge core_clk);
    ctxSave <= 1'b0;
    shIdx = '{`PCLD_IDX_STATUS_SHD, `PCLD_IDX_WREG_SHD, `PCLD_IDX_BSR_SHD, `PCLD_IDX_LATCH_SHD,
              `PCLD_IDX_FSR0L_SHD, `PCLD_IDX_FSR0H_SHD, `PCLD_IDX_FSR1L_SHD, `PCLD_IDX_FSR1H_SHD};
    shExp = '{8'h05, 8'ha5, 8'h13, 8'h7f, 8'h34, 8'h12, 8'hef, 8'hbe};
    for (int i = 0; i < 8; i++)
    begin
      apb(1'b0, shIdx[i], 8'h00, rd);
      chk(rd, shExp[i]);
    end
    apb(1'b1, `PCLD_IDX_BSR_SHD, 8'hff, rd);
    apb(1'b0, `PCLD_IDX_BSR_SHD, 8'h00, rd);
    chk(rd, 8'h1f);
    apb(1'b0, 12'hfec, 8'h00, rd);
    chk(rd, 8'h00);
    apb(1'b0, 12'h003, 8'h00, rd);
    chk(rd, 8'h00);
    // Top bank closed to user code
    @(posedge core_clk);
    debugMode <= 1'b0;
    apb(1'b0, `PCLD_IDX_WREG_SHD, 8'h00, rd);
    chk(rd, 8'h00);
    apb(1'b1, `PCLD_IDX_WREG_SHD, 8'h11, rd);
    @(posedge core_clk);
    debugMode <= 1'b1;
    apb(1'b0, `PCLD_IDX_WREG_SHD, 8'h00, rd);
    chk(rd, 8'ha5);
    chk(pslverr, 1'b0);
    // Computed jump into a table: latch set to the table's block first
    apb(1'b1, `PCLD_IDX_PC_LATCH, 8'h13, rd);
    exec(PCLD_OP_WRLOW, 11'h000, 8'h80);
    chk(pcOut, 15'h1380);
    exec(PCLD_OP_CALL, 11'h123, 8'h00);
    chk(pcOut, 15'h1123);
    // Reset in mid-run clears counter and latch and sets the pointer back to 1f
    @(posedge core_clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    arst_n <= 1'b1;
    @(negedge core_clk);
    chk(pcOut, 15'h0000);
    chk(stkPtrOut, 5'h1f);
    apb(1'b0, `PCLD_IDX_PC_LATCH, 8'h00, rd);
    chk(rd, 8'h00);
    close_out();
  end
endmodule
